// [inc/tws_pkg.sv]
// constants and types for the tx wave shaping configuration bank
package tws_pkg;
    // ----------------------------------------------------------------
    // bus shape
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 14;
    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CAL_LOW = 14'h0502;
    localparam logic [IDX_W-1:0] IDX_CAL_HIGH = 14'h0503;
    localparam logic [IDX_W-1:0] IDX_CAL_THRESH = 14'h0504;
    localparam logic [IDX_W-1:0] IDX_MIN_OFFS = 14'h0505;
    localparam logic [IDX_W-1:0] IDX_MAX_OFFS = 14'h0509;
    localparam logic [IDX_W-1:0] IDX_RESID_AMPL = 14'h050e;
    localparam logic [IDX_W-1:0] IDX_SHAPE_SEL = 14'h050f;
    localparam logic [IDX_W-1:0] IDX_SHAPE_PARAM = 14'h0510;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0520;
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int FALL_SEL_LSB = 4;
    localparam int RISE_SEL_LSB = 0;
    localparam int SEL_W = 4;
    localparam int FALL_STYLE_LSB = 4;
    localparam int RISE_STYLE_LSB = 0;
    localparam int STYLE_W = 3;
    localparam int LUT_IDX_W = 2;
    localparam int OFF_W = 5;
    localparam int OFF_STRIDE = 8;
    localparam int OFF_NUM = 4;
    localparam int ST_FALL_BAD = 0;
    localparam int ST_RISE_BAD = 1;
    localparam int ST_ABOVE = 2;
    // ----------------------------------------------------------------
    // edge shape codes
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] CODE_FW1 = 4'h1;
    localparam logic [SEL_W-1:0] CODE_FW2 = 4'h2;
    localparam logic [SEL_W-1:0] CODE_FW3 = 4'h3;
    localparam logic [SEL_W-1:0] CODE_LUT_FIXED = 4'h4;
    localparam logic [SEL_W-1:0] CODE_LUT_CORR = 4'h5;
    localparam logic [SEL_W-1:0] CODE_LUT_NOCORR = 4'h6;
    localparam logic [STYLE_W-1:0] LUT_IDX_MAX = 3'h3;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    typedef enum logic [2:0] {
        TWS_FW_ONE, TWS_FW_TWO, TWS_FW_THREE,
        TWS_LUT_FIXED, TWS_LUT_CORR, TWS_LUT_NOCORR
    } tws_shape_t;
endpackage : tws_pkg

// [core/tws_shaping_config.sv]
// register bank and decode for type a edge wave shaping
`timescale 1ns/10ps
module tws_shaping_config import tws_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] ampSupplyCode,
    output logic [7:0] carrierLevel,
    output tws_shape_t fallShape,
    output tws_shape_t riseShape,
    output logic [STYLE_W-1:0] fallTimeConst,
    output logic [STYLE_W-1:0] riseTimeConst,
    output logic [LUT_IDX_W-1:0] fallLutIndex,
    output logic [LUT_IDX_W-1:0] riseLutIndex,
    output logic fallSelectInvalid,
    output logic riseSelectInvalid,
    output logic supplyAboveThreshold,
    output logic [OFF_W-1:0] threeSegmentOffset,
    output logic [OFF_W-1:0] threeSegmentOffsetSecond,
    output logic [OFF_W-1:0] twoSegmentOffset0,
    output logic [OFF_W-1:0] twoSegmentOffset1
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] laneMerge(input logic [31:0] old,
            input logic [31:0] wdata, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction : laneMerge

    // reserved codes fall back to the gentlest shaping, one linear ramp
    function automatic tws_shape_t shapeOf(input logic [SEL_W-1:0] code);
        tws_shape_t s;
        s = TWS_FW_ONE;
        unique case (code)
            CODE_FW2: s = TWS_FW_TWO;
            CODE_FW3: s = TWS_FW_THREE;
            CODE_LUT_FIXED: s = TWS_LUT_FIXED;
            CODE_LUT_CORR: s = TWS_LUT_CORR;
            CODE_LUT_NOCORR: s = TWS_LUT_NOCORR;
            default: s = TWS_FW_ONE;
        endcase
        return s;
    endfunction : shapeOf

    function automatic logic codeBad(input logic [SEL_W-1:0] code);
        return (code < CODE_FW1) || (code > CODE_LUT_NOCORR);
    endfunction : codeBad

    function automatic logic isLut(input tws_shape_t s);
        return (s == TWS_LUT_FIXED) || (s == TWS_LUT_CORR) || (s == TWS_LUT_NOCORR);
    endfunction : isLut

    // out-of-range table numbers clamp to the last table
    function automatic logic [LUT_IDX_W-1:0] lutIdx(input logic [STYLE_W-1:0] f);
        return (f > LUT_IDX_MAX) ? LUT_IDX_MAX[LUT_IDX_W-1:0] : f[LUT_IDX_W-1:0];
    endfunction : lutIdx

    // ----------------------------------------------------------------
    // bus slave: one wait state per access
    // ----------------------------------------------------------------
    logic ack_q;
    logic busReq;
    logic wrTake;
    logic [IDX_W-1:0] regIdx;
    assign busReq = avs_read || avs_write;
    assign avs_waitrequest = busReq && !ack_q;
    assign wrTake = avs_write && ack_q;
    assign regIdx = avs_address[ADDR_W-1:2];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq && !ack_q;
        end
    end

    // ----------------------------------------------------------------
    // storage (all bits kept, reserved ones too)
    // ----------------------------------------------------------------
    logic [7:0] calLow_q;
    logic [7:0] calHigh_q;
    logic [7:0] calThresh_q;
    logic [31:0] minOffs_q;
    logic [31:0] maxOffs_q;
    logic [7:0] residAmpl_q;
    logic [7:0] shapeSel_q;
    logic [7:0] shapeParam_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            calLow_q <= RST_BYTE;
            calHigh_q <= RST_BYTE;
            calThresh_q <= RST_BYTE;
            minOffs_q <= RST_WORD;
            maxOffs_q <= RST_WORD;
            residAmpl_q <= RST_BYTE;
            shapeSel_q <= RST_BYTE;
            shapeParam_q <= RST_BYTE;
        end else if (wrTake) begin
            if (avs_byteenable[0]) begin
                unique case (regIdx)
                    IDX_CAL_LOW: calLow_q <= avs_writedata[7:0];
                    IDX_CAL_HIGH: calHigh_q <= avs_writedata[7:0];
                    IDX_CAL_THRESH: calThresh_q <= avs_writedata[7:0];
                    IDX_RESID_AMPL: residAmpl_q <= avs_writedata[7:0];
                    IDX_SHAPE_SEL: shapeSel_q <= avs_writedata[7:0];
                    IDX_SHAPE_PARAM: shapeParam_q <= avs_writedata[7:0];
                    default: ;
                endcase
            end
            if (regIdx == IDX_MIN_OFFS) begin
                minOffs_q <= laneMerge(minOffs_q, avs_writedata, avs_byteenable);
            end
            if (regIdx == IDX_MAX_OFFS) begin
                maxOffs_q <= laneMerge(maxOffs_q, avs_writedata, avs_byteenable);
            end
        end
    end

    // ----------------------------------------------------------------
    // supply code from the pin: three stages, change taken on agreement
    // ----------------------------------------------------------------
    logic [7:0] supS1_q;
    logic [7:0] supS2_q;
    logic [7:0] supS3_q;
    logic [7:0] supply_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            supS1_q <= RST_BYTE;
            supS2_q <= RST_BYTE;
            supS3_q <= RST_BYTE;
            supply_q <= RST_BYTE;
        end else begin
            supS1_q <= ampSupplyCode;
            supS2_q <= supS1_q;
            supS3_q <= supS2_q;
            if (supS2_q == supS3_q) begin
                supply_q <= supS3_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    tws_shape_t fallShape_d;
    tws_shape_t riseShape_d;
    logic [STYLE_W-1:0] fallStyle;
    logic [STYLE_W-1:0] riseStyle;
    logic useMax;
    logic [31:0] offWord;
    logic [OFF_W-1:0] offField [OFF_NUM];

    assign fallShape_d = shapeOf(shapeSel_q[FALL_SEL_LSB +: SEL_W]);
    assign riseShape_d = shapeOf(shapeSel_q[RISE_SEL_LSB +: SEL_W]);
    // bits 7 and 3 never reach the decode
    assign fallStyle = shapeParam_q[FALL_STYLE_LSB +: STYLE_W];
    assign riseStyle = shapeParam_q[RISE_STYLE_LSB +: STYLE_W];
    // threshold code itself still belongs to the low group
    assign useMax = supply_q > calThresh_q;
    assign offWord = useMax ? maxOffs_q : minOffs_q;

    generate
        for (genvar g = 0; g < OFF_NUM; g++) begin : gOff
            assign offField[g] = offWord[g*OFF_STRIDE +: OFF_W];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fallShape <= TWS_FW_ONE;
            riseShape <= TWS_FW_ONE;
            fallTimeConst <= '0;
            riseTimeConst <= '0;
            fallLutIndex <= '0;
            riseLutIndex <= '0;
            fallSelectInvalid <= 1'b1;
            riseSelectInvalid <= 1'b1;
        end else begin
            fallShape <= fallShape_d;
            riseShape <= riseShape_d;
            fallSelectInvalid <= codeBad(shapeSel_q[FALL_SEL_LSB +: SEL_W]);
            riseSelectInvalid <= codeBad(shapeSel_q[RISE_SEL_LSB +: SEL_W]);
            fallTimeConst <= isLut(fallShape_d) ? '0 : fallStyle;
            fallLutIndex <= isLut(fallShape_d) ? lutIdx(fallStyle) : '0;
            riseTimeConst <= isLut(riseShape_d) ? '0 : riseStyle;
            riseLutIndex <= isLut(riseShape_d) ? lutIdx(riseStyle) : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            carrierLevel <= RST_BYTE;
            supplyAboveThreshold <= 1'b0;
            threeSegmentOffset <= '0;
            threeSegmentOffsetSecond <= '0;
            twoSegmentOffset0 <= '0;
            twoSegmentOffset1 <= '0;
        end else begin
            carrierLevel <= residAmpl_q;
            supplyAboveThreshold <= useMax;
            threeSegmentOffset <= offField[0];
            threeSegmentOffsetSecond <= offField[1];
            twoSegmentOffset0 <= offField[2];
            twoSegmentOffset1 <= offField[3];
        end
    end

    // ----------------------------------------------------------------
    // read mux, registered during the wait state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        rdMux = '0;
        unique case (regIdx)
            IDX_CAL_LOW: rdMux = {24'h00_0000, calLow_q};
            IDX_CAL_HIGH: rdMux = {24'h00_0000, calHigh_q};
            IDX_CAL_THRESH: rdMux = {24'h00_0000, calThresh_q};
            IDX_MIN_OFFS: rdMux = minOffs_q;
            IDX_MAX_OFFS: rdMux = maxOffs_q;
            IDX_RESID_AMPL: rdMux = {24'h00_0000, residAmpl_q};
            IDX_SHAPE_SEL: rdMux = {24'h00_0000, shapeSel_q};
            IDX_SHAPE_PARAM: rdMux = {24'h00_0000, shapeParam_q};
            IDX_STATUS: begin
                rdMux[ST_FALL_BAD] = fallSelectInvalid;
                rdMux[ST_RISE_BAD] = riseSelectInvalid;
                rdMux[ST_ABOVE] = supplyAboveThreshold;
            end
            default: rdMux = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rdMux;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence sReqOpen;
        busReq && !ack_q;
    endsequence
    sequence sWaitThenGo;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    a_bus_wait_state: assert property (sReqOpen |-> sWaitThenGo)
        else $error("access not answered after one wait state");
    a_param_readback: assert property (wrTake && avs_byteenable[0]
            && regIdx == IDX_SHAPE_PARAM |=> shapeParam_q == $past(avs_writedata[7:0]))
        else $error("style parameter not stored whole");
    a_fall_code_map: assert property (shapeSel_q[7:4] == CODE_FW2
            |=> fallShape == TWS_FW_TWO)
        else $error("falling selector decoded wrongly");
    a_rise_code_map: assert property (shapeSel_q[3:0] == CODE_LUT_CORR
            |=> riseShape == TWS_LUT_CORR && !riseSelectInvalid)
        else $error("rising selector decoded wrongly");
    a_fall_time_const: assert property (shapeSel_q[7:4] == CODE_FW3
            |=> fallTimeConst == $past(shapeParam_q[6:4]) && fallLutIndex == 2'h0)
        else $error("falling time constant wrong");
    a_fall_lut_index: assert property (shapeSel_q[7:4] == CODE_LUT_NOCORR
            && shapeParam_q[6:4] <= 3'h3 |=> fallLutIndex == $past(shapeParam_q[5:4]))
        else $error("falling table index wrong");
    a_rise_style_use: assert property (shapeSel_q[3:0] == CODE_FW1
            |=> riseTimeConst == $past(shapeParam_q[2:0]) && riseShape == TWS_FW_ONE)
        else $error("rising style wrong");
    a_carrier_level: assert property (##1 carrierLevel == $past(residAmpl_q))
        else $error("carrier level does not follow residual amplitude");
    a_offset_min: assert property (!useMax |=> !supplyAboveThreshold
            && twoSegmentOffset1 == $past(minOffs_q[28:24])
            && threeSegmentOffset == $past(minOffs_q[4:0]))
        else $error("low supply offsets wrong");
    a_offset_max: assert property (useMax |=> supplyAboveThreshold
            && twoSegmentOffset0 == $past(maxOffs_q[20:16])
            && threeSegmentOffsetSecond == $past(maxOffs_q[12:8]))
        else $error("high supply offsets wrong");
    a_bad_code_flag: assert property (shapeSel_q[7:4] > 4'h6
            |=> fallSelectInvalid && fallShape == TWS_FW_ONE)
        else $error("reserved falling code not caught");
endmodule : tws_shaping_config

// [dv/tb_top.sv]
// self-checking testbench for the type a edge wave shaping register bank
`timescale 1ns/10ps
module tb_top import tws_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] ampSupplyCode = 8'h00;
    logic [7:0] carrierLevel;
    tws_shape_t fallShape;
    tws_shape_t riseShape;
    logic [STYLE_W-1:0] fallTimeConst;
    logic [STYLE_W-1:0] riseTimeConst;
    logic [LUT_IDX_W-1:0] fallLutIndex;
    logic [LUT_IDX_W-1:0] riseLutIndex;
    logic fallSelectInvalid;
    logic riseSelectInvalid;
    logic supplyAboveThreshold;
    logic [OFF_W-1:0] threeSegmentOffset;
    logic [OFF_W-1:0] threeSegmentOffsetSecond;
    logic [OFF_W-1:0] twoSegmentOffset0;
    logic [OFF_W-1:0] twoSegmentOffset1;
    int mismatches = 0;
    int tests_run = 0;

    always #20 clk_sys = ~clk_sys;

    tws_shaping_config dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ampSupplyCode(ampSupplyCode),
        .carrierLevel(carrierLevel), .fallShape(fallShape), .riseShape(riseShape),
        .fallTimeConst(fallTimeConst), .riseTimeConst(riseTimeConst),
        .fallLutIndex(fallLutIndex), .riseLutIndex(riseLutIndex),
        .fallSelectInvalid(fallSelectInvalid), .riseSelectInvalid(riseSelectInvalid),
        .supplyAboveThreshold(supplyAboveThreshold), .threeSegmentOffset(threeSegmentOffset),
        .threeSegmentOffsetSecond(threeSegmentOffsetSecond),
        .twoSegmentOffset0(twoSegmentOffset0), .twoSegmentOffset1(twoSegmentOffset1));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string msg);
        tests_run++;
        if (seen !== expv) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, expv);
        end
    endtask : check

    // request held until waitrequest is sampled low; only the watchdog ends a hang
    task automatic bus(input logic isWr, input logic [IDX_W-1:0] idx, input logic [31:0] d,
            input logic [3:0] be, output logic [31:0] rdat);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_write <= isWr;
        avs_read <= !isWr;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] dummy;
        bus(1'b1, idx, d, be, dummy);
    endtask : wr

    task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] v);
        bus(1'b0, idx, 32'h0, 4'hf, v);
    endtask : rd

    // decoded outputs land one edge after the stored value
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_and_map();
        logic [IDX_W-1:0] idx [9] = '{IDX_CAL_LOW, IDX_CAL_HIGH, IDX_CAL_THRESH, IDX_MIN_OFFS,
            IDX_MAX_OFFS, IDX_RESID_AMPL, IDX_SHAPE_SEL, IDX_SHAPE_PARAM, 14'h0600};
        logic [31:0] v;
        check(fallSelectInvalid & riseSelectInvalid, 1'b1, "reset invalid flags");
        check(fallShape, TWS_FW_ONE, "reset fallback shape");
        for (int i = 0; i < 9; i++) begin
            rd(idx[i], v);
            check(v, 32'h0, "reset value");
        end
        wr(14'h0600, 32'hffff_ffff, 4'hf);
        rd(14'h0600, v);
        check(v, 32'h0, "unmapped read");
        wr(IDX_CAL_HIGH, 32'hffff_ff24, 4'hf);
        rd(IDX_CAL_HIGH, v);
        check(v, 32'h24, "8-bit register upper bits");
    endtask : test_reset_and_map

    task automatic edge_exp(input logic [3:0] code, input logic [2:0] sty, input tws_shape_t sh,
            input logic [2:0] tc, input logic [1:0] li, input logic inv);
        logic lut;
        logic bad;
        lut = code inside {[4'h4:4'h6]};
        bad = !(code inside {[4'h1:4'h6]});
        check(sh, bad ? TWS_FW_ONE : tws_shape_t'(3'(code - 4'h1)), "shape");
        check(tc, lut ? 3'h0 : sty, "time constant");
        check(li, lut ? ((sty > 3'h3) ? 2'h3 : sty[1:0]) : 2'h0, "table index");
        check(inv, bad, "invalid flag");
    endtask : edge_exp

    // every nibble code on both edges, rising code reversed so the two differ
    task automatic test_edges();
        logic [3:0] f;
        logic [3:0] r;
        logic [7:0] p;
        logic [31:0] v;
        for (int c = 0; c < 16; c++) begin
            f = 4'(c);
            r = 4'(15 - c);
            // table codes meet in-range indices on the fall side; on the rise side only code 4 meets a clamped one
            p = {1'b1, 3'(c + 4), 1'b1, 3'(c + 1)};
            wr(IDX_SHAPE_SEL, {24'h0, f, r}, 4'h1);
            wr(IDX_SHAPE_PARAM, {24'h0, p}, 4'h1);
            settle();
            edge_exp(f, p[6:4], fallShape, fallTimeConst, fallLutIndex, fallSelectInvalid);
            edge_exp(r, p[2:0], riseShape, riseTimeConst, riseLutIndex, riseSelectInvalid);
            rd(IDX_SHAPE_PARAM, v);
            check(v, {24'h0, p}, "style readback with reserved bits");
            rd(IDX_STATUS, v);
            check(v[1:0], {!(r inside {[4'h1:4'h6]}), !(f inside {[4'h1:4'h6]})},
                "status flags");
        end
    endtask : test_edges

    task automatic test_carrier();
        wr(IDX_RESID_AMPL, 32'h0000_00ff, 4'h1);
        settle();
        check(carrierLevel, 8'hff, "full carrier");
        wr(IDX_RESID_AMPL, 32'h0000_005a, 4'he);
        settle();
        check(carrierLevel, 8'hff, "lane 0 off ignored");
        wr(IDX_RESID_AMPL, 32'h0000_0000, 4'h1);
        settle();
        check(carrierLevel, 8'h00, "no carrier");
    endtask : test_carrier

    task automatic offs_exp(input logic [31:0] w);
        check(threeSegmentOffset, w[4:0], "offset 4:0");
        check(threeSegmentOffsetSecond, w[12:8], "offset 12:8");
        check(twoSegmentOffset0, w[20:16], "offset 20:16");
        check(twoSegmentOffset1, w[28:24], "offset 28:24");
    endtask : offs_exp

    // supply exactly at threshold stays in the minimum group
    task automatic test_offsets();
        logic [31:0] v;
        wr(IDX_CAL_THRESH, 32'h0000_0008, 4'h1);
        wr(IDX_MIN_OFFS, 32'head5_cbb1, 4'hf);
        wr(IDX_MAX_OFFS, 32'hffff_ffff, 4'hf);
        wr(IDX_MAX_OFFS, 32'h3f7e_5dc4, 4'h5);
        @(posedge clk_sys);
        ampSupplyCode <= 8'h08;
        repeat (10) @(posedge clk_sys);
        #1;
        check(supplyAboveThreshold, 1'b0, "equal to threshold");
        offs_exp(32'head5_cbb1);
        @(posedge clk_sys);
        ampSupplyCode <= 8'h09;
        repeat (10) @(posedge clk_sys);
        #1;
        check(supplyAboveThreshold, 1'b1, "above threshold");
        offs_exp(32'hff7e_ffc4);
        rd(IDX_STATUS, v);
        check(v[2], 1'b1, "status above bit");
        rd(IDX_MIN_OFFS, v);
        check(v, 32'head5_cbb1, "min word readback");
        rd(IDX_MAX_OFFS, v);
        check(v, 32'hff7e_ffc4, "max word lane merge");
    endtask : test_offsets

    // ----------------------------------------------------------------
    // closing and main sequence
    // ----------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    // whole run is a few hundred cycles; this limit is far beyond it
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        results();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle();
        test_reset_and_map();
        test_edges();
        test_carrier();
        test_offsets();
        results();
    end
endmodule : tb_top
